// ==== pkg/ebd_pkg.sv ====
package ebd_pkg;

    // ------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------
    localparam logic [15:0] SPECIAL_HI = 16'h0017; // Top of special regs
    localparam logic [15:0] RAM_HI = 16'h01FF;     // Top of register RAM
    localparam logic [15:0] ROM_LO = 16'h2000;     // On-chip program memory
    localparam logic [15:0] ROM_HI = 16'h5FFF;     // End of program memory
    localparam logic [15:0] NMI_VECTOR = 16'h203E; // Nonmaskable vector

    // ------------------------------------------------------------
    // Register bus map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CONFIG = 8'h00; // chip_config_register
    localparam logic [7:0] OFS_STATUS = 8'h04; // Bus controller state

    // Config fields
    localparam int CFG_DYN_WIDTH = 1;   // 1: width from input each cycle
    localparam int CFG_VALID_MODE = 2;  // 1: address valid form
    localparam int CFG_BYTE_WRITE = 3;  // 1: per-byte write strobes
    localparam logic [7:0] CFG_RESET = 8'h00; // Config after reset

    // Status fields
    localparam int STS_BUSY = 0;   // External cycle in progress
    localparam int STS_HOLD = 1;   // Bus released to other master
    localparam int STS_WIDE = 2;   // Last cycle ran 16 bits wide
    localparam int STS_EXT_SEL = 3; // external_access_select level

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    // Where an access is steered
    typedef enum logic [1:0] {
        T_EXTERNAL = 2'h0,
        T_SPECIAL = 2'h1,
        T_RAM = 2'h2,
        T_ROM = 2'h3
    } ebd_target_t;

    // Bus sequencer states, one-hot
    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_ADDR = 5'h02,
        S_DATA = 5'h04,
        S_GAP = 5'h08,
        S_HOLD = 5'h10
    } ebd_state_t;

endpackage : ebd_pkg

// ==== core/ebd_core.sv ====
`timescale 1ns/1ps
// Overview of operation
// - 2000H-5FFFH internal when select high, else external
// - Fetches from 0000H-01FFH always go external
// - Data at 0018H-01FFH goes to register RAM
// - Data at 0000H-0017H goes to special regs
// - Config bit 1 set: width input picks 16/8
// - Config bit 1 clear: every cycle 8-bit
// - Fetch flag high on external fetch reads only
// - Strobe is latch pulse or valid, valid ends high
// - Address strobe only on external accesses
// - Read strobe only on external reads
// - Low write strobe: every write or even bytes
// - High pin: high-byte enable or odd-byte write
// - Ready stretches external cycles, ignored otherwise
// - Rising nonmaskable event vectors through 203EH
// - Clock output runs at half the input clock
// - Hold request answered by release acknowledge
// - Pending request raised while bus is held
// - Address then data on shared multiplexed lines
module ebd_core (
    input wire logic i_mclk,
    input wire logic i_rstn,
    // Processor side request port
    input wire logic i_req,
    input wire logic [15:0] i_req_addr,
    input wire logic i_req_we,
    input wire logic i_req_fetch,
    input wire logic i_req_word,
    input wire logic [15:0] i_req_wdata,
    output logic o_req_done,
    output logic [15:0] o_req_rdata,
    output logic [1:0] o_req_target,
    // External multiplexed bus
    input wire logic [15:0] i_ad_in,
    output logic [15:0] o_ad_out,
    output logic o_ad_oe,
    output logic o_addr_strobe,
    output logic o_read_n,
    output logic o_store_low_strobe_n,
    output logic o_store_high_strobe_n,
    output logic o_opcode_fetch_flag,
    input wire logic i_ready,
    input wire logic i_buswidth,
    input wire logic i_external_access_select,
    input wire logic i_hold,
    output logic o_bus_release_ack,
    output logic o_pending_cycle_request,
    // Nonmaskable event and clock output
    input wire logic i_nmi,
    output logic o_nmi_take,
    output logic [15:0] o_nmi_vector,
    output logic o_clock_output,
    // Wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack
);

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // Used by request intake and hold pending logic
    function automatic ebd_pkg::ebd_target_t ebd_decode(
        input logic [15:0] addr,
        input logic fetch,
        input logic sel
    );
        ebd_pkg::ebd_target_t t;
        t = ebd_pkg::T_EXTERNAL;
        if (fetch && addr <= ebd_pkg::RAM_HI)
            t = ebd_pkg::T_EXTERNAL;
        else if (addr <= ebd_pkg::SPECIAL_HI)
            t = ebd_pkg::T_SPECIAL;
        else if (addr <= ebd_pkg::RAM_HI)
            t = ebd_pkg::T_RAM;
        else if (sel && addr >= ebd_pkg::ROM_LO && addr <= ebd_pkg::ROM_HI)
            t = ebd_pkg::T_ROM;
        return t;                             // Rest external
    endfunction : ebd_decode

    // ------------------------------------------------------------
    // State and latched request
    // ------------------------------------------------------------
    ebd_pkg::ebd_state_t state; // Sequencer state
    ebd_pkg::ebd_state_t next_state;
    logic [7:0] config_reg; // chip_config_register
    logic [15:0] cur_addr; // Latched request address
    logic cur_we; // Latched direction
    logic cur_fetch; // Latched fetch kind
    logic cur_word; // Latched word size
    logic [15:0] cur_wdata; // Latched write data
    logic second; // Second byte beat of word
    logic more_beat; // Another beat follows the gap
    logic cyc16; // Width of current cycle
    logic nmi_prev; // Previous event level

    // Decoded intake
    ebd_pkg::ebd_target_t dec;
    logic take;
    logic take_ext;
    logic take_int;
    logic dyn_width;
    logic valid_mode;
    logic byte_write;
    logic width_now;
    logic a0;
    logic lo_lane;
    logic hi_lane;
    logic even_wr;
    logic odd_wr;
    logic as_idle;
    logic as_active;
    logic more_now;

    // Next values of registered outputs
    logic [15:0] next_ad;
    logic next_oe;
    logic next_as;
    logic next_rd_n;
    logic next_wl_n;
    logic next_wh_n;
    logic next_fetch;

    assign dyn_width = config_reg[ebd_pkg::CFG_DYN_WIDTH];
    assign valid_mode = config_reg[ebd_pkg::CFG_VALID_MODE];
    assign byte_write = config_reg[ebd_pkg::CFG_BYTE_WRITE];
    assign dec = ebd_decode(i_req_addr, i_req_fetch,
        i_external_access_select);
    // A done pulse means the core is still dropping its request
    assign take = (state == ebd_pkg::S_IDLE) && i_req && !o_req_done
        && !i_hold;
    assign take_ext = take && (dec == ebd_pkg::T_EXTERNAL);
    assign take_int = take && (dec != ebd_pkg::T_EXTERNAL);
    // Latch form idles low, valid form idles high
    assign as_idle = valid_mode;
    assign as_active = !valid_mode;
    // Width is fixed once a split word has started
    assign width_now = second ? 1'b0 : (dyn_width & i_buswidth);
    assign a0 = cur_addr[0] | second;
    assign more_now = cur_word && !cyc16 && !second;

    // ------------------------------------------------------------
    // Byte lanes of the data phase
    // ------------------------------------------------------------
    always_comb
    begin
        if (width_now)
        begin
            lo_lane = cur_word | !a0;
            hi_lane = cur_word | a0;
            even_wr = lo_lane;
            odd_wr = hi_lane;
        end
        else
        begin
            // Narrow bus carries every byte on the low lane
            lo_lane = 1'b1;
            hi_lane = 1'b0;
            even_wr = !a0;
            odd_wr = a0;
        end
    end

    // ------------------------------------------------------------
    // Sequencer next state and pin values
    // ------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        next_ad = o_ad_out;
        next_oe = o_ad_oe;
        next_as = o_addr_strobe;
        next_rd_n = 1'b1;
        next_wl_n = 1'b1;
        next_wh_n = 1'b1;
        next_fetch = o_opcode_fetch_flag;
        case (state)
            ebd_pkg::S_IDLE:
            begin
                // Pins stay quiet for internal accesses
                next_oe = 1'b0;
                next_as = as_idle;
                next_fetch = 1'b0;
                if (i_hold)
                    next_state = ebd_pkg::S_HOLD;
                else if (take_ext)
                begin
                    // Address goes out first on shared lines
                    next_state = ebd_pkg::S_ADDR;
                    next_ad = i_req_addr;
                    next_oe = 1'b1;
                    next_as = as_active;
                    next_fetch = i_req_fetch & !i_req_we;
                end
            end
            ebd_pkg::S_ADDR:
            begin
                // Latch pulse ends; valid form stays low
                next_state = ebd_pkg::S_DATA;
                next_as = 1'b0;
                if (cur_we)
                begin
                    next_oe = 1'b1;
                    if (width_now)
                        next_ad = cur_word ? cur_wdata
                            : {cur_wdata[7:0], cur_wdata[7:0]};
                    else
                        next_ad = {8'h00,
                            second ? cur_wdata[15:8] : cur_wdata[7:0]};
                    next_wl_n = byte_write ? !even_wr : 1'b0;
                    next_wh_n = byte_write ? !odd_wr : !hi_lane;
                end
                else
                begin
                    next_oe = 1'b0;
                    next_rd_n = 1'b0;
                end
            end
            ebd_pkg::S_DATA:
            begin
                if (i_ready)
                begin
                    // Valid form returns high at cycle end
                    next_state = ebd_pkg::S_GAP;
                    next_as = as_idle;
                    next_oe = 1'b0;
                    next_fetch = 1'b0;
                end
                else
                begin
                    // Stretched while ready is low
                    next_rd_n = o_read_n;
                    next_wl_n = o_store_low_strobe_n;
                    next_wh_n = o_store_high_strobe_n;
                end
            end
            ebd_pkg::S_GAP:
            begin
                if (more_beat)
                begin
                    next_state = ebd_pkg::S_ADDR;
                    next_ad = {cur_addr[15:1], 1'b1};
                    next_oe = 1'b1;
                    next_as = as_active;
                    next_fetch = cur_fetch & !cur_we;
                end
                else
                    next_state = ebd_pkg::S_IDLE;
            end
            ebd_pkg::S_HOLD:
            begin
                // Bus lines released to the other master
                next_oe = 1'b0;
                next_as = as_idle;
                next_fetch = 1'b0;
                if (!i_hold)
                    next_state = ebd_pkg::S_IDLE;
            end
            default:
                next_state = ebd_pkg::S_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // Sequencer registers and pins
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state <= ebd_pkg::S_IDLE;
            o_ad_out <= 16'h0000;
            o_ad_oe <= 1'b0;
            o_addr_strobe <= 1'b0;
            o_read_n <= 1'b1;
            o_store_low_strobe_n <= 1'b1;
            o_store_high_strobe_n <= 1'b1;
            o_opcode_fetch_flag <= 1'b0;
            o_bus_release_ack <= 1'b0;
            o_pending_cycle_request <= 1'b0;
        end
        else
        begin
            state <= next_state;
            o_ad_out <= next_ad;
            o_ad_oe <= next_oe;
            o_addr_strobe <= next_as;
            o_read_n <= next_rd_n;
            o_store_low_strobe_n <= next_wl_n;
            o_store_high_strobe_n <= next_wh_n;
            o_opcode_fetch_flag <= next_fetch;
            o_bus_release_ack <= (next_state == ebd_pkg::S_HOLD);
            // Own external work waits behind the other master
            o_pending_cycle_request <= (next_state == ebd_pkg::S_HOLD)
                && i_req && !o_req_done && (dec == ebd_pkg::T_EXTERNAL);
        end
    end

    // ------------------------------------------------------------
    // Request latch, beat tracking and answer
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            cur_addr <= 16'h0000;
            cur_we <= 1'b0;
            cur_fetch <= 1'b0;
            cur_word <= 1'b0;
            cur_wdata <= 16'h0000;
            second <= 1'b0;
            more_beat <= 1'b0;
            cyc16 <= 1'b0;
            o_req_done <= 1'b0;
            o_req_rdata <= 16'h0000;
            o_req_target <= 2'h0;
        end
        else
        begin
            o_req_done <= take_int;
            if (take)
            begin
                cur_addr <= i_req_addr;
                cur_we <= i_req_we;
                cur_fetch <= i_req_fetch;
                cur_word <= i_req_word;
                cur_wdata <= i_req_wdata;
                second <= 1'b0;
                o_req_target <= dec;
                o_req_rdata <= 16'h0000;
            end
            if (state == ebd_pkg::S_ADDR)
                cyc16 <= width_now;
            if (state == ebd_pkg::S_GAP && more_beat)
                second <= 1'b1;
            if (state == ebd_pkg::S_DATA && i_ready)
            begin
                more_beat <= more_now;
                o_req_done <= !more_now;
                if (cyc16)
                    o_req_rdata <= cur_word ? i_ad_in
                        : {8'h00, a0 ? i_ad_in[15:8] : i_ad_in[7:0]};
                else if (second)
                    o_req_rdata[15:8] <= i_ad_in[7:0];
                else
                    o_req_rdata <= {8'h00, i_ad_in[7:0]};
            end
        end
    end

    // ------------------------------------------------------------
    // Nonmaskable event and clock output
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            nmi_prev <= 1'b0;
            o_nmi_take <= 1'b0;
            o_nmi_vector <= ebd_pkg::NMI_VECTOR;
            o_clock_output <= 1'b0;
        end
        else
        begin
            nmi_prev <= i_nmi;
            o_nmi_take <= i_nmi && !nmi_prev;
            o_nmi_vector <= ebd_pkg::NMI_VECTOR;
            o_clock_output <= !o_clock_output;
        end
    end

    // ------------------------------------------------------------
    // Wishbone slave: config and status
    // ------------------------------------------------------------
    // One wait-free answer; unmapped reads return zero
    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            config_reg <= ebd_pkg::CFG_RESET;
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0000_0000;
        end
        else
        begin
            o_wb_ack <= i_wb_cyc && i_wb_stb && !o_wb_ack;
            o_wb_dat <= 32'h0000_0000;
            if (i_wb_cyc && i_wb_stb && !o_wb_ack)
            begin
                if (i_wb_we && i_wb_sel[0]
                    && i_wb_adr == ebd_pkg::OFS_CONFIG)
                    config_reg <= i_wb_dat[7:0];
                else if (!i_wb_we && i_wb_adr == ebd_pkg::OFS_CONFIG)
                    o_wb_dat <= {24'h00_0000, config_reg};
                else if (!i_wb_we && i_wb_adr == ebd_pkg::OFS_STATUS)
                    o_wb_dat <= {28'h000_0000, i_external_access_select,
                        cyc16, o_bus_release_ack,
                        (state != ebd_pkg::S_IDLE
                        && state != ebd_pkg::S_HOLD)};
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);

    sequence seq_take_int;
        take_int;
    endsequence
    sequence seq_answer_only;
        o_req_done && !o_ad_oe && o_read_n && o_addr_strobe == as_idle;
    endsequence
    sequence seq_hold_grant;
        o_bus_release_ack && !o_ad_oe;
    endsequence

    a_rom_route: assert property (take && i_external_access_select
        && i_req_addr >= ebd_pkg::ROM_LO && i_req_addr <= ebd_pkg::ROM_HI
        && !(i_req_fetch && i_req_addr <= ebd_pkg::RAM_HI)
        |=> o_req_target == ebd_pkg::T_ROM && o_req_done)
        else $error("program memory range not routed inside");
    a_boot_fetch: assert property (take && i_req_fetch
        && i_req_addr <= ebd_pkg::RAM_HI |=> state == ebd_pkg::S_ADDR)
        else $error("low fetch not run externally");
    a_ram_data: assert property (take && !i_req_fetch
        && i_req_addr > ebd_pkg::SPECIAL_HI && i_req_addr <= ebd_pkg::RAM_HI
        |=> o_req_target == ebd_pkg::T_RAM)
        else $error("register RAM access misrouted");
    a_special_data: assert property (take && !i_req_fetch
        && i_req_addr <= ebd_pkg::SPECIAL_HI
        |=> o_req_target == ebd_pkg::T_SPECIAL)
        else $error("special register access misrouted");
    a_width_sample: assert property (state == ebd_pkg::S_ADDR
        && !second && dyn_width |=> cyc16 == $past(i_buswidth))
        else $error("bus width not sampled");
    a_width_fixed: assert property (!dyn_width
        && state == ebd_pkg::S_ADDR |=> !cyc16)
        else $error("wide cycle with fixed width");
    a_fetch_flag: assert property (state == ebd_pkg::S_DATA
        |-> o_opcode_fetch_flag == (cur_fetch && !cur_we))
        else $error("fetch flag wrong in data phase");
    a_valid_end: assert property (valid_mode
        && state == ebd_pkg::S_DATA && i_ready |=> o_addr_strobe)
        else $error("valid strobe not ended");
    a_quiet_int: assert property (seq_take_int |=> seq_answer_only)
        else $error("bus activity on internal access");
    a_read_only: assert property (!o_read_n
        |-> state == ebd_pkg::S_DATA && !cur_we)
        else $error("read strobe outside external read");
    a_low_store: assert property (!byte_write
        && state == ebd_pkg::S_ADDR && cur_we |=> !o_store_low_strobe_n)
        else $error("write strobe missing");
    a_high_store: assert property (!o_store_high_strobe_n
        |-> state == ebd_pkg::S_DATA && cur_we)
        else $error("high strobe outside write");
    a_ready_wait: assert property (state == ebd_pkg::S_DATA && !i_ready
        |=> state == ebd_pkg::S_DATA && $stable(o_read_n))
        else $error("cycle ended without ready");
    a_nmi_take: assert property ($rose(i_nmi) |=> o_nmi_take
        && o_nmi_vector == ebd_pkg::NMI_VECTOR)
        else $error("event not vectored");
    a_clock_half: assert property (o_clock_output ##1 !o_clock_output
        |=> o_clock_output) else $error("clock output not toggling");
    a_hold_ack: assert property (state == ebd_pkg::S_IDLE && i_hold
        |=> seq_hold_grant) else $error("hold not acknowledged");
    a_pending_req: assert property (o_pending_cycle_request
        |-> o_bus_release_ack) else $error("pending request without hold");
    a_mux_addr: assert property (state == ebd_pkg::S_ADDR
        |-> o_ad_oe && o_ad_out[15:1] == cur_addr[15:1])
        else $error("address not on shared lines");
    a_ext_other: assert property (take && !i_req_fetch
        && i_req_addr > ebd_pkg::ROM_HI |=> state == ebd_pkg::S_ADDR)
        else $error("undecoded address not external");

endmodule : ebd_core

// ==== bench/ebd_mem_model.sv ====
`timescale 1ns/1ps
// External memory: address pattern data, optional waits
module ebd_mem_model (
    input wire logic i_mclk,
    input wire logic [15:0] i_ad,
    input wire logic i_oe,
    input wire logic i_rd_n,
    input wire logic i_busy,
    input wire logic i_wide,
    input wire logic i_slow,
    output logic [15:0] o_ad,
    output logic o_rdy,
    output logic o_bw
);
    logic [15:0] a;
    logic [15:0] last = 16'h0000;
    logic [1:0] w = 2'h0;
    logic rsv; // Reserved image byte addressed
    // Latch address phase, count strobe cycles
    always @(posedge i_mclk)
    begin
        if (i_oe)
            a <= i_ad;
        if (!i_rd_n)
            last <= o_ad;
        w <= i_busy ? w + 2'h1 : 2'h0;
    end
    // Released bus shows inverse, so stale data never matches
    // Program image: reserved bytes filler, 2019 fixed
    assign rsv = a >= 16'h2014 && a <= 16'h201F && a != 16'h2018;
    assign o_ad = i_rd_n ? ~last
        : rsv ? {2{(a == 16'h2019) ? 8'h20 : 8'hFF}}
        : {a[7:0] | 8'h01, a[7:0]} ^ 16'h5A5A;
    // Idle ready is low in slow mode on purpose: it must be ignored then
    assign o_rdy = !(i_slow && w < 2'h2);
    assign o_bw = i_wide;
endmodule : ebd_mem_model

// ==== bench/external_bus_decode_test.sv ====
`timescale 1ns/1ps
module external_bus_decode_test;
    logic mclk = 1'b0, rstn = 1'b0, req = 1'b0, we = 1'b0, fetch = 1'b0;
    logic word = 1'b1, sel = 1'b1, hold = 1'b0, nmi = 1'b0, wide = 1'b0;
    logic slow = 1'b0, cyc = 1'b0, wwe = 1'b0, seen_if, c0;
    logic done, oe, astb, rd_n, wl_n, wh_n, ifl, rdy, bw, ack;
    logic take, pend, rel, cko;
    logic [1:0] tgt;
    logic [7:0] wadr = 8'h00;
    logic [15:0] addr = 16'h0000, ad_in, ad_out, rdata, vec, wd;
    logic [31:0] wdat = 32'h0, wrd, got;
    // Decode cases: addr, fetch, select, target; no reserved
    logic [19:0] tbl [7] = '{20'h00105, 20'h01006, 20'h0100C, 20'h30007,
        20'h30000, 20'h1FFE4, 20'h80004};
    // Write cases: config, addr bit 0, word, low, high; spare 0
    logic [11:0] wt [5] = '{12'h0A9, 12'h0A2, 12'h027, 12'h02B, 12'h0A7};
    int mismatches = 0, n_checks = 0, ncy, t0, t1;
    int cnt [5] = '{default: 0};
    always #20 mclk = ~mclk;
    ebd_core dut_u (.i_mclk(mclk), .i_rstn(rstn), .i_req(req),
        .i_req_addr(addr), .i_req_we(we), .i_req_fetch(fetch),
        .i_req_word(word), .i_req_wdata(16'h1234), .o_req_done(done),
        .o_req_rdata(rdata), .o_req_target(tgt), .i_ad_in(ad_in),
        .o_ad_out(ad_out), .o_ad_oe(oe), .o_addr_strobe(astb),
        .o_read_n(rd_n), .o_store_low_strobe_n(wl_n),
        .o_store_high_strobe_n(wh_n), .o_opcode_fetch_flag(ifl),
        .i_ready(rdy), .i_buswidth(bw), .i_external_access_select(sel),
        .i_hold(hold), .o_bus_release_ack(rel),
        .o_pending_cycle_request(pend), .i_nmi(nmi), .o_nmi_take(take),
        .o_nmi_vector(vec), .o_clock_output(cko), .i_wb_cyc(cyc),
        .i_wb_stb(cyc), .i_wb_we(wwe), .i_wb_adr(wadr), .i_wb_sel(4'hF),
        .i_wb_dat(wdat), .o_wb_dat(wrd), .o_wb_ack(ack));
    ebd_mem_model mem_u (.i_mclk(mclk), .i_ad(ad_out), .i_oe(oe),
        .i_rd_n(rd_n), .i_busy(!(rd_n && wl_n && wh_n)), .i_wide(wide),
        .i_slow(slow), .o_ad(ad_in), .o_rdy(rdy), .o_bw(bw));
    // Strobe event counts: read, low, high, latch rise, valid fall
    always @(posedge mclk)
    begin
        cnt[0] += $fell(rd_n);
        cnt[1] += $fell(wl_n);
        cnt[2] += $fell(wh_n);
        cnt[3] += $rose(astb);
        cnt[4] += $fell(astb);
        seen_if |= ifl;
        if (!(wl_n && wh_n))
            wd = ad_out;
    end
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("ERROR %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    // Bounded wait for a handshake, edge value sampled
    task automatic await(ref logic s);
        ncy = 0;
        do
        begin
            @(posedge mclk);
            ncy++;
        end
        while (s !== 1'b1 && ncy < 200);
        if (ncy >= 200)
        begin
            $display("ERROR %0t: wait timed out", $time);
            mismatches++;
            conclude();
        end
    endtask : await
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge mclk);
        cyc <= 1'b1;
        wwe <= w;
        wadr <= a;
        wdat <= d;
        await(ack);
        got = wrd;
        cyc <= 1'b0;
    endtask : wb
    task automatic acc(input logic [15:0] a, input logic f, w, wd);
        cnt = '{default: 0};
        seen_if = 1'b0;
        @(posedge mclk);
        {req, addr, fetch, we, word} <= {1'b1, a, f, w, wd};
        await(done);
        req <= 1'b0;
    endtask : acc
    initial
    begin
        repeat (16) @(posedge mclk);
        rstn <= 1'b1;
        wb(1'b1, 8'h08, 32'hFF);
        wb(1'b0, ebd_pkg::OFS_CONFIG, 32'h0);
        chk(got, {24'h0, ebd_pkg::CFG_RESET});
        wb(1'b0, 8'h08, 32'h0);
        chk(got, 32'h0);
        foreach (tbl[i])
        begin
            sel <= tbl[i][2];
            acc(tbl[i][19:4], tbl[i][3], 1'b0, 1'b1);
            t0 = (tbl[i][1:0] == 2'h0);
            chk(tgt, tbl[i][1:0]);
            chk(cnt[3], t0 ? 2 : 0);
            chk(cnt[0], t0 ? 2 : 0);
            chk(seen_if, t0 && tbl[i][3]);
            chk(rdata, t0 ? {tbl[i][11:4] | 8'h01,
                tbl[i][11:4]} ^ 16'h5A5A : 0);
        end
        $display("decode test done");
        for (int k = 0; k < 4; k++)
        begin
            wb(1'b1, ebd_pkg::OFS_CONFIG, {30'h0, k[1], 1'b0});
            wide <= k[0];
            acc(16'h8000, 1'b0, 1'b0, 1'b1);
            chk(cnt[0], (k == 3) ? 1 : 2);
            chk(rdata, 16'h5B5A);
        end
        t0 = ncy;
        acc(16'h0100, 1'b0, 1'b0, 1'b1);
        t1 = ncy;
        slow <= 1'b1;
        acc(16'h8000, 1'b0, 1'b0, 1'b1);
        chk(ncy > t0, 1);
        acc(16'h0100, 1'b0, 1'b0, 1'b1);
        chk(ncy, t1);
        slow <= 1'b0;
        $display("width and ready test done");
        foreach (wt[i])
        begin
            wb(1'b1, ebd_pkg::OFS_CONFIG, {24'h0, wt[i][11:4]});
            acc({15'h4000, wt[i][3]}, 1'b0, 1'b1, wt[i][2]);
            chk({cnt[1] == 1, cnt[2] == 1}, wt[i][1:0]);
            chk(cnt[0], 0);
            chk(wd, wt[i][2] ? 16'h1234 : 16'h3434);
        end
        wb(1'b1, ebd_pkg::OFS_CONFIG, 32'h06);
        acc(16'h8000, 1'b0, 1'b0, 1'b1);
        chk(cnt[4], 1);
        chk(astb, 1'b1);
        $display("strobe test done");
        hold <= 1'b1;
        await(rel);
        wb(1'b0, ebd_pkg::OFS_STATUS, 32'h0);
        chk(got, 32'hE);
        fork
            acc(16'h8000, 1'b0, 1'b0, 1'b1);
            begin
                repeat (4) @(posedge mclk);
                chk(pend, 1'b1);
                hold <= 1'b0;
            end
        join
        chk(rel, 1'b0);
        nmi <= 1'b1;
        await(take);
        chk(vec, ebd_pkg::NMI_VECTOR);
        c0 = cko;
        @(posedge mclk);
        chk(cko, !c0);
        $display("hold, event and clock test done");
        conclude();
    end
endmodule : external_bus_decode_test
